/* File: psp_pkg.sv */
// shared constants and types for the protection stage pick-up block
package psp_pkg;
	localparam int           MAG_W           = 16;
	localparam int           RATIO_PCT       = 97;
	localparam logic [2:0]   MODE_RESET      = 3'h0;
	localparam logic [3:0]   OBJ_RESET       = 4'h0;
	localparam logic [3:0]   OBJ_LAST        = 4'h9;
	localparam logic [1:0]   FAULT_W2        = 2'h0;
	localparam int           TICK_HZ_NUM     = 125_000_000;
	localparam int           BLOCK_LEAD_MS   = 5;
	localparam int           BLOCK_LEAD_CYC  = TICK_HZ_NUM / 1000 * BLOCK_LEAD_MS;

	typedef enum logic [2:0]
	{
		MODE_ON,
		MODE_BLOCKED,
		MODE_TEST,
		MODE_TEST_BLOCKED,
		MODE_OFF
	} psp_mode_e;

	typedef enum logic
	{
		ROT_ABC,
		ROT_ACB
	} psp_rot_e;
endpackage : psp_pkg

/* File: psp_evt_if.sv */
// carries stage verdict and event information between the block's modules
`timescale 1ns/1ps
interface psp_evt_if;
	logic                    pickup;
	logic                    started;
	logic                    inhibited;
	logic                    release_pulse;
	logic                    block_event;
	logic [psp_pkg::MAG_W-1:0] event_mag;
	logic                    event_under;

	modport stage
	(
		input  pickup,
		output started,
		output inhibited,
		output release_pulse,
		output block_event,
		output event_mag,
		output event_under
	);
	modport sink
	(
		input  pickup,
		input  started,
		input  inhibited,
		input  release_pulse,
		input  block_event,
		input  event_mag,
		input  event_under
	);
endinterface : psp_evt_if

/* File: psp_compare.sv */
// pick-up comparator with fixed reset-ratio hysteresis
`timescale 1ns/1ps
module psp_compare
(
	input  wire logic                      ref_clk,   // system clock
	input  wire logic                      rst_n,     // synchronised reset
	input  wire logic                      tick,      // program-cycle tick
	input  wire logic                      under,     // 1: under-magnitude stage
	input  wire logic [psp_pkg::MAG_W-1:0] level,     // pick-up level
	input  wire logic [psp_pkg::MAG_W-1:0] mag,       // measured magnitude
	output logic                           pickup     // pick-up element state
);
	function automatic logic [psp_pkg::MAG_W+6:0] scale(input logic [psp_pkg::MAG_W-1:0] v, input int pct);
		scale = (psp_pkg::MAG_W+7)'(v) * (psp_pkg::MAG_W+7)'(pct);
	endfunction : scale

	// compare mag*100 with level*pct to avoid a divider
	wire logic [psp_pkg::MAG_W+6:0] mag_x100  = scale(mag, 100);
	wire logic [psp_pkg::MAG_W+6:0] lvl_x100  = scale(level, 100);
	wire logic [psp_pkg::MAG_W+6:0] lvl_reset = scale(level, psp_pkg::RATIO_PCT);
	// release for under stages sits on the far side of the level: level/0.97
	wire logic [psp_pkg::MAG_W+6:0] mag_x97   = scale(mag, psp_pkg::RATIO_PCT);

	wire logic over_act   = mag_x100 > lvl_x100;
	wire logic over_rel   = mag_x100 < lvl_reset;
	wire logic under_act  = mag_x100 < lvl_x100;
	wire logic under_rel  = mag_x97 > lvl_x100;
	wire logic act        = under ? under_act : over_act;
	wire logic rel        = under ? under_rel : over_rel;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			pickup <= 1'b0;
		else if (tick)
			pickup <= pickup ? !rel : act;
	end
endmodule : psp_compare

/* File: psp_stage.sv */
// protection stage front end: pick-up, blocking, start and general commands
`timescale 1ns/1ps
// Notes on behaviour
// - pick-up level is the maximum or minimum allowed magnitude; act on crossing.
// - ratio of level to measured magnitude decides the pick-up element state.
// - release only when magnitude returns past 97 % of the level, or past level/0.97 for under stages.
// - blocking input is sampled at the start of every program cycle.
// - pick-up while unblocked asserts started and hands on to timing.
// - pick-up while blocked asserts inhibited and pulses the display and block events, nothing further.
// - blocking after start clears started and pulses release handling.
// - blocking raises display and time-stamped events with current and fault type.
// - latch reset clears all latches, command returns to idle by itself.
// - latch-reset logical input acts like the front-panel back key.
// - a logical input clears the last recorded fault register.
// - phase-order input 0 selects A-B-C, 1 selects A-C-B.
// - device mode on, blocked, test, test-blocked, off; default on; gated by permission.
// - push-button LEDs follow one of ten objects, default the first.
// - configured phase rotation sets expected wiring, default A-B-C.
module psp_stage
(
	input  wire logic                      ref_clk,        // 125 MHz clock
	input  wire logic                      reset_n,        // async reset, active low
	input  wire logic                      tick,           // program-cycle tick, same domain
	input  wire logic                      under,          // stage is under-magnitude type
	input  wire logic [psp_pkg::MAG_W-1:0] level,          // pick-up level
	input  wire logic [psp_pkg::MAG_W-1:0] mag,            // measured magnitude
	input  wire logic [1:0]                fault_type,     // fault type from measurement
	input  wire logic                      block_pin,      // blocking matrix input (async)
	input  wire logic                      latch_reset_cmd,// setting command pulse
	input  wire logic                      latch_reset_in, // logical input
	input  wire logic                      back_key,       // front-panel back key (async)
	input  wire logic                      fault_clr_in,   // clear last fault logical input
	input  wire logic                      fault_capture,  // record a fault now
	input  wire logic                      rot_setting,    // configured rotation, 0 abc
	input  wire logic                      rot_logic_en,   // logical input overrides setting
	input  wire logic                      phase_order_select, // 0 abc, 1 acb
	input  wire logic                      mode_allowed,   // device-mode setting permitted
	input  wire logic                      mode_wr,        // write a new mode
	input  wire logic [2:0]                mode_in,        // requested mode
	input  wire logic                      obj_wr,         // write object selection
	input  wire logic [3:0]                obj_in,         // 0 first .. 9 tenth
	input  wire logic [9:0]                obj_closed,     // object closed status
	input  wire logic [9:0]                obj_open,       // object open status
	input  wire logic                      latch_set,      // event to latch in the matrix
	output logic                           started,        // start output
	output logic                           inhibited,      // blocked output
	output logic                           release_pulse,  // run release-time handling
	output logic                           display_event,  // display event pulse
	output logic                           block_event,    // time-stamped block event pulse
	output logic [psp_pkg::MAG_W-1:0]      event_mag,      // current at start
	output logic [1:0]                     event_fault,    // fault type in event
	output logic                           latch_q,        // latched matrix signal
	output logic                           latch_cmd_state,// reset command setting, idle 0
	output logic                           fault_valid,    // last fault register occupied
	output logic [1:0]                     fault_reg,      // last fault type
	output logic                           rot_acb,        // expected rotation a-c-b
	output logic [2:0]                     mode,           // device mode
	output logic                           mode_visible,   // mode setting exposed
	output logic [3:0]                     obj_sel,        // selected object
	output logic                           led_close,      // close button LED
	output logic                           led_open        // open button LED
);
	logic       rst_s1;
	logic       rst_n_s;
	logic       blk_s1;
	logic       blk_s2;
	logic       key_s1;
	logic       key_s2;
	logic       key_d;

	psp_evt_if evt ();

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rst_s1  <= 1'b0;
			rst_n_s <= 1'b0;
		end
		else
		begin
			rst_s1  <= 1'b1;
			rst_n_s <= rst_s1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
		begin
			blk_s1 <= 1'b0;
			blk_s2 <= 1'b0;
			key_s1 <= 1'b0;
			key_s2 <= 1'b0;
			key_d  <= 1'b0;
		end
		else
		begin
			blk_s1 <= block_pin;
			blk_s2 <= blk_s1;
			key_s1 <= back_key;
			key_s2 <= key_s1;
			key_d  <= key_s2;
		end
	end

	// device mode blocked states also block the stage
	wire logic mode_blocks = (mode == 3'(psp_pkg::MODE_BLOCKED)) || (mode == 3'(psp_pkg::MODE_TEST_BLOCKED))
	                      || (mode == 3'(psp_pkg::MODE_OFF));
	wire logic blk_now     = blk_s2 || mode_blocks;

	psp_compare u_cmp
	(
		.ref_clk (ref_clk),
		.rst_n   (rst_n_s),
		.tick    (tick),
		.under   (under),
		.level   (level),
		.mag     (mag),
		.pickup  (evt.pickup)
	);

	psp_decide u_dec
	(
		.ref_clk   (ref_clk),
		.rst_n     (rst_n_s),
		.tick      (tick),
		.blk       (blk_now),
		.mag       (mag),
		.under     (under),
		.evt       (evt.stage)
	);

	assign started       = evt.started;
	assign inhibited     = evt.inhibited;
	assign release_pulse = evt.release_pulse;
	assign block_event   = evt.block_event;
	assign display_event = evt.block_event;
	assign event_mag     = evt.event_mag;

	// fault type captured on each tick while the element is picked up and block_event is low
	always_ff @(posedge ref_clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
			event_fault <= psp_pkg::FAULT_W2;
		else if (tick && evt.pickup && !evt.block_event)
			event_fault <= fault_type;
	end

	wire logic key_edge   = key_s2 && !key_d;
	wire logic latch_clr  = latch_reset_cmd || latch_reset_in || key_edge;

	// a set arriving in the clearing cycle wins
	always_ff @(posedge ref_clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
			latch_q <= 1'b0;
		else if (latch_set)
			latch_q <= 1'b1;
		else if (latch_clr)
			latch_q <= 1'b0;
	end

	// command setting shows reset for one cycle then returns to idle
	always_ff @(posedge ref_clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
			latch_cmd_state <= 1'b0;
		else
			latch_cmd_state <= latch_reset_cmd;
	end

	always_ff @(posedge ref_clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
		begin
			fault_valid <= 1'b0;
			fault_reg   <= psp_pkg::FAULT_W2;
		end
		else if (fault_capture)
		begin
			fault_valid <= 1'b1;
			fault_reg   <= fault_type;
		end
		else if (fault_clr_in)
		begin
			fault_valid <= 1'b0;
			fault_reg   <= psp_pkg::FAULT_W2;
		end
	end

	wire logic next_rot = rot_logic_en ? phase_order_select : rot_setting;

	always_ff @(posedge ref_clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
			rot_acb <= 1'b0;
		else
			rot_acb <= next_rot;
	end

	wire logic mode_ok = mode_wr && mode_allowed && (mode_in <= 3'(psp_pkg::MODE_OFF));

	always_ff @(posedge ref_clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
			mode <= psp_pkg::MODE_RESET;
		else if (mode_ok)
			mode <= mode_in;
	end

	assign mode_visible = mode_allowed;

	wire logic obj_ok = obj_wr && (obj_in <= psp_pkg::OBJ_LAST);

	always_ff @(posedge ref_clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
			obj_sel <= psp_pkg::OBJ_RESET;
		else if (obj_ok)
			obj_sel <= obj_in;
	end

	always_ff @(posedge ref_clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
		begin
			led_close <= 1'b0;
			led_open  <= 1'b0;
		end
		else
		begin
			led_close <= obj_closed[obj_sel];
			led_open  <= obj_open[obj_sel];
		end
	end

endmodule : psp_stage

/* File: psp_decide.sv */
// start / blocked decision made once per program cycle
`timescale 1ns/1ps
module psp_decide
(
	input  wire logic                      ref_clk,  // system clock
	input  wire logic                      rst_n,    // synchronised reset
	input  wire logic                      tick,     // program-cycle tick
	input  wire logic                      blk,      // blocking level
	input  wire logic [psp_pkg::MAG_W-1:0] mag,      // measured magnitude
	input  wire logic                      under,    // polarity hint, registered out as event_under
	psp_evt_if.stage                       evt       // verdict outputs
);
	logic started;
	logic inhibited;
	logic rel;
	logic bev;
	logic [psp_pkg::MAG_W-1:0] emag;
	logic under_q;

	// pickup is updated on this same tick, so use last cycle's pickup
	// decisions lag the comparator by one tick; blocking is checked first
	wire logic pk        = evt.pickup;
	wire logic go_start  = tick && pk && !blk && !inhibited;
	wire logic go_block  = tick && pk && blk && !started && !inhibited;
	wire logic kill      = tick && started && blk;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			started   <= 1'b0;
			inhibited <= 1'b0;
			rel       <= 1'b0;
			bev       <= 1'b0;
			emag      <= '0;
			under_q   <= 1'b0;
		end
		else
		begin
			under_q <= under;
			rel     <= tick && started && (blk || !pk);
			bev     <= go_block || kill;
			if (go_start)
				emag <= mag;
			if (tick)
			begin
				started   <= pk && !blk && (started || !inhibited);
				inhibited <= pk && (inhibited || blk);
			end
		end
	end

	assign evt.started       = started;
	assign evt.inhibited     = inhibited;
	assign evt.release_pulse = rel;
	assign evt.block_event   = bev;
	assign evt.event_mag     = emag;
	assign evt.event_under   = under_q;
endmodule : psp_decide

/* File: psp_props.sv */
// concurrent checks on the pick-up stage top ports
`timescale 1ns/1ps
module psp_props
(
	input wire logic       ref_clk,            // clock
	input wire logic       reset_n,            // reset
	input wire logic       tick,               // cycle tick
	input wire logic       mode_allowed,       // mode permit
	input wire logic       mode_wr,            // mode write
	input wire logic [2:0] mode_in,            // mode asked
	input wire logic       obj_wr,             // object write
	input wire logic [3:0] obj_in,             // object asked
	input wire logic       rot_setting,        // rotation setting
	input wire logic       rot_logic_en,       // rotation override
	input wire logic       phase_order_select, // rotation input
	input wire logic       latch_reset_cmd,    // reset command
	input wire logic       fault_clr_in,       // fault clear
	input wire logic       fault_capture,      // fault record
	input wire logic       started,            // start
	input wire logic       inhibited,          // blocked
	input wire logic       release_pulse,      // release
	input wire logic       display_event,      // display event
	input wire logic       block_event,        // block event
	input wire logic [2:0] mode,               // mode
	input wire logic       mode_visible,       // mode exposed
	input wire logic [3:0] obj_sel,            // object
	input wire logic       rot_acb,            // rotation
	input wire logic       latch_cmd_state,    // command setting
	input wire logic       fault_valid         // fault held
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	sequence cmd_echo;
		latch_cmd_state ##1 !latch_cmd_state;
	endsequence
	start_tick_a: assert property (!tick |=> $stable(started))
		else $error("start moved off tick");
	inhib_tick_a: assert property ($changed(inhibited) |-> $past(tick))
		else $error("blocked moved off tick");
	verdict_excl_a: assert property (!(started && inhibited))
		else $error("start and blocked together");
	release_step_a: assert property (release_pulse |-> $fell(started) ##1 !release_pulse)
		else $error("release without start drop");
	block_event_a: assert property (block_event |-> display_event ##1 !block_event)
		else $error("block event malformed");
	mode_vis_a: assert property (mode_visible == mode_allowed)
		else $error("mode exposure wrong");
	mode_take_a: assert property (mode_wr && mode_allowed && mode_in <= 3'h4 |=> mode == $past(mode_in))
		else $error("mode write lost");
	mode_keep_a: assert property (mode_wr && !(mode_allowed && mode_in <= 3'h4) |=> $stable(mode))
		else $error("bad mode write taken");
	obj_take_a: assert property (obj_wr |=> obj_sel == ($past(obj_in) <= 4'h9 ? $past(obj_in) : $past(obj_sel)))
		else $error("object select wrong");
	cmd_idle_a: assert property (latch_reset_cmd |=> cmd_echo)
		else $error("command not back to idle");
	rot_pick_a: assert property (rot_acb == ($past(rot_logic_en) ? $past(phase_order_select) : $past(rot_setting)))
		else $error("rotation wrong");
	fault_clr_a: assert property (fault_clr_in && !fault_capture |=> !fault_valid)
		else $error("fault not cleared");
endmodule : psp_props
bind psp_stage psp_props u_props (.*);

/* File: psp_far.sv */
// far-side model: program-cycle tick, measurement chain and blocking matrix
`timescale 1ns/1ps
module psp_far
#(
	parameter int TICK_DIV = 8 // cycles per program cycle, shortened for run time
)
(
	input wire logic                      ref_clk,    // clock
	input wire logic                      reset_n,    // reset, active low
	input wire logic [psp_pkg::MAG_W-1:0] want_mag,   // magnitude to present
	input wire logic                      want_blk,   // blocking request
	input wire logic [1:0]                want_flt,   // fault type to present
	output logic                          tick,       // program-cycle tick
	output logic [psp_pkg::MAG_W-1:0]     mag,        // measured magnitude
	output logic                          block_pin,  // blocking matrix output
	output logic [1:0]                    fault_type  // fault type
);
	logic [7:0] cnt;
	wire        wrap = (cnt == 8'(TICK_DIV - 1));
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cnt <= 8'h00;
			tick <= 1'h0;
			mag <= '0;
			block_pin <= 1'h0;
			fault_type <= 2'h0;
		end
		else
		begin
			cnt <= wrap ? 8'h00 : cnt + 8'h01;
			tick <= wrap;
			// measurement only refreshes once per program cycle
			if (wrap)
				mag <= want_mag;
			block_pin <= want_blk;
			fault_type <= want_flt;
		end
	end
endmodule : psp_far

/* File: testbench.sv */
// self-checking bench for the pick-up stage
`timescale 1ns/1ps
module testbench;
	logic ref_clk = 0, reset_n = 0, under = 0, latch_reset_cmd = 0, latch_reset_in = 0, back_key = 0;
	logic fault_clr_in = 0, fault_capture = 0, rot_setting = 0, rot_logic_en = 0, phase_order_select = 0;
	logic mode_allowed = 0, mode_wr = 0, obj_wr = 0, latch_set = 0, want_blk = 0;
	logic [2:0] mode_in = '0;
	logic [3:0] obj_in = '0;
	logic [9:0] obj_closed = '0, obj_open = '0;
	logic [15:0] level = '0, want_mag = '0;
	logic [1:0] want_flt = '0;
	logic tick, block_pin, started, inhibited, release_pulse, display_event, block_event, latch_q;
	logic latch_cmd_state, fault_valid, rot_acb, mode_visible, led_close, led_open;
	logic [15:0] mag, event_mag;
	logic [1:0] fault_type, event_fault, fault_reg;
	logic [2:0] mode;
	logic [3:0] obj_sel;
	localparam logic [9:0] CL = 10'h2aa;
	int miscompares = 0, tests_run = 0, n_rel = 0, n_blk = 0, n_dsp = 0, e;
	always #4 ref_clk = ~ref_clk;
	psp_stage DUT (.*);
	psp_far u_far (.ref_clk(ref_clk), .reset_n(reset_n), .want_mag(want_mag), .want_blk(want_blk),
		.want_flt(want_flt), .tick(tick), .mag(mag), .block_pin(block_pin), .fault_type(fault_type));
	always @(posedge ref_clk)
	begin
		if (release_pulse === 1'h1) n_rel++;
		if (block_event === 1'h1) n_blk++;
		if (display_event === 1'h1) n_dsp++;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : cyc
	task automatic ticks(input int n);
		repeat (n) @(posedge tick);
		cyc(2);
	endtask : ticks
	task chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task done(input string s);
		$display("test %s finished", s);
	endtask : done
	task wrap_up;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : wrap_up
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		wrap_up;
	end
	initial
	begin
		cyc(2);
		reset_n <= 1'h1;
		cyc(3);
		chk(started, 0); chk(inhibited, 0); chk(mode, 0); chk(obj_sel, 0); chk(latch_q, 0);
		done("reset");
		level <= 16'h03e8;
		want_mag <= 16'h044c;
		ticks(4);
		chk(started, 1); chk(inhibited, 0);
		want_mag <= 16'h03d4;
		ticks(4);
		chk(started, 1);
		want_mag <= 16'h03c0;
		ticks(4);
		chk(started, 0);
		done("over pickup");
		want_mag <= 16'h044c;
		want_flt <= 2'h2;
		ticks(4);
		chk(started, 1);
		n_rel = 0;
		n_blk = 0;
		n_dsp = 0;
		want_blk <= 1'h1;
		ticks(4);
		chk(started, 0); chk(n_rel, 1); chk(n_blk, 1);
		chk(n_dsp, 1);
		chk(event_mag, 16'h044c); chk(event_fault, 2'h2);
		want_mag <= 16'h0000;
		ticks(4);
		want_blk <= 1'h0;
		ticks(2);
		want_blk <= 1'h1;
		ticks(2);
		want_mag <= 16'h044c;
		ticks(4);
		chk(inhibited, 1); chk(started, 0);
		done("blocking");
		// a blocked pick-up holds until the element drops, so let it drop first
		want_blk <= 1'h0;
		want_mag <= 16'h0000;
		ticks(4);
		chk(inhibited, 0); chk(started, 0);
		under <= 1'h1;
		want_mag <= 16'h0384;
		ticks(4);
		chk(started, 1);
		want_mag <= 16'h03fc;
		ticks(4);
		chk(started, 1);
		want_mag <= 16'h0410;
		ticks(4);
		chk(started, 0);
		under <= 1'h0;
		done("under pickup");
		for (int r = 0; r < 8; r++)
		begin
			{rot_logic_en, phase_order_select, rot_setting} <= r[2:0];
			cyc(3);
			chk(rot_acb, r[2] ? r[1] : r[0]);
		end
		done("rotation");
		obj_closed <= CL;
		obj_open <= ~CL;
		for (int o = 0; o < 11; o++)
		begin
			obj_in <= o[3:0];
			obj_wr <= 1'h1;
			cyc(1);
			obj_wr <= 1'h0;
			cyc(3);
			e = (o < 10) ? o : 9;
			chk(obj_sel, e); chk(led_close, CL[e]); chk(led_open, !CL[e]);
		end
		done("objects");
		for (int k = 0; k < 3; k++)
		begin
			latch_set <= 1'h1;
			cyc(1);
			latch_set <= 1'h0;
			cyc(2);
			chk(latch_q, 1);
			{back_key, latch_reset_in, latch_reset_cmd} <= 3'h1 << k;
			cyc(1);
			{back_key, latch_reset_in, latch_reset_cmd} <= 3'h0;
			cyc(5);
			chk(latch_q, 0);
		end
		done("latches");
		want_flt <= 2'h3;
		cyc(2);
		fault_capture <= 1'h1;
		cyc(1);
		fault_capture <= 1'h0;
		cyc(2);
		chk(fault_valid, 1); chk(fault_reg, 2'h3);
		fault_clr_in <= 1'h1;
		cyc(1);
		fault_clr_in <= 1'h0;
		cyc(2);
		chk(fault_valid, 0);
		done("fault clear");
		mode_allowed <= 1'h1;
		for (int m = 0; m < 6; m++)
		begin
			mode_in <= m[2:0];
			mode_wr <= 1'h1;
			cyc(1);
			mode_wr <= 1'h0;
			cyc(2);
			chk(mode, (m < 5) ? m : 4); chk(mode_visible, 1);
		end
		mode_allowed <= 1'h0;
		mode_in <= 3'h1;
		mode_wr <= 1'h1;
		cyc(1);
		mode_wr <= 1'h0;
		cyc(2);
		chk(mode, 4); chk(mode_visible, 0);
		done("modes");
		wrap_up;
	end
endmodule : testbench
